// File: design/cws_pkg.sv
// Constants, types and default step tables shared by the control write sequencer.
package cws_pkg;

    // Register offsets as seen by the control interface.
    localparam logic [7:0] REG_SLOT_SELECT  = 8'h46;
    localparam logic [7:0] REG_TARGET_DESC  = 8'h47;
    localparam logic [7:0] REG_DATA_DESC    = 8'h48;
    localparam logic [7:0] REG_SEQ_START    = 8'h49;
    localparam logic [7:0] REG_SEQ_STATUS   = 8'h4a;
    localparam logic [7:0] REG_SEQ_PROGRESS = 8'h4b;

    // Field positions.
    localparam int SLOT_IDX_MSB   = 3;
    localparam int ENABLE_BIT     = 8;
    localparam int WIDTH_MSB      = 14;
    localparam int WIDTH_LSB      = 12;
    localparam int POS_MSB        = 11;
    localparam int POS_LSB        = 8;
    localparam int ADDR_MSB       = 7;
    localparam int END_BIT        = 14;
    localparam int DELAY_MSB      = 11;
    localparam int DELAY_LSB      = 8;
    localparam int VALUE_MSB      = 7;
    localparam int CANCEL_BIT     = 9;
    localparam int GO_BIT         = 8;
    localparam int FIRST_MSB      = 5;
    localparam int RUNNING_BIT    = 0;
    localparam int DONE_BIT       = 1;

    // Step memory map.
    localparam logic [5:0] RAM_LAST   = 6'h0f;
    localparam logic [5:0] ROM_LAST   = 6'h3a;
    localparam logic [3:0] SLOT_LAST  = 4'hf;
    localparam logic [7:0] DUMMY_ADDR = 8'hff;

    // Timing: one delay unit is 62.5 us, each step lasts (2^D + 8) units.
    localparam int unsigned STEP_UNIT_PS    = 62500000;
    localparam int unsigned CLK_PERIOD_PS   = 100000;
    localparam int unsigned TICK_CYCLES_DEF = STEP_UNIT_PS / CLK_PERIOD_PS;
    localparam logic [16:0] STEP_FIXED_TICKS = 17'h00008;

    typedef struct packed {
        logic       endFlag;
        logic [3:0] delayCode;
        logic [7:0] writeValue;
        logic [2:0] widthCode;
        logic [3:0] lsbPos;
        logic [7:0] targetAddr;
    } cws_step_t;

    typedef struct packed {
        logic        wrEn;
        logic [7:0]  addr;
        logic [15:0] wrData;
    } cws_reg_req_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] mask;
        logic [15:0] data;
    } cws_ctrl_wr_t;

    typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT} cws_state_t;

    function automatic cws_step_t mkStep(input logic [7:0] a, input logic [2:0] w, input logic [3:0] p,
                                         input logic [7:0] v, input logic [3:0] d, input logic e);
        mkStep = '{endFlag: e, delayCode: d, writeValue: v, widthCode: w, lsbPos: p, targetAddr: a};
    endfunction

    // Power-up RAM contents (0..15) and fixed ROM contents (16..58).
    // Unpopulated locations hold a terminating dummy write so a stray start cannot run away.
    function automatic cws_step_t cwsDefaultStep(input logic [5:0] idx);
        unique case (idx)
            6'h00:   cwsDefaultStep = mkStep(8'h4c, 3'h0, 4'hf, 8'h01, 4'h6, 1'b0);
            6'h01:   cwsDefaultStep = mkStep(8'h01, 3'h2, 4'h7, 8'h07, 4'h0, 1'b0);
            6'h02:   cwsDefaultStep = mkStep(8'h60, 3'h4, 4'h1, 8'h11, 4'h0, 1'b0);
            6'h03:   cwsDefaultStep = mkStep(8'h54, 3'h6, 4'h0, 8'h33, 4'h9, 1'b0);
            6'h04:   cwsDefaultStep = mkStep(8'hff, 3'h0, 4'h0, 8'h00, 4'h5, 1'b0);
            6'h05:   cwsDefaultStep = mkStep(8'hff, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h06:   cwsDefaultStep = mkStep(8'hff, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h07:   cwsDefaultStep = mkStep(8'h60, 3'h5, 4'h2, 8'h3b, 4'h0, 1'b1);
            6'h10:   cwsDefaultStep = mkStep(8'h60, 3'h6, 4'h1, 8'h00, 4'h0, 1'b0);
            6'h11:   cwsDefaultStep = mkStep(8'h54, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h12:   cwsDefaultStep = mkStep(8'h01, 3'h1, 4'h8, 8'h00, 4'h0, 1'b0);
            6'h13:   cwsDefaultStep = mkStep(8'h4c, 3'h0, 4'hf, 8'h00, 4'h0, 1'b0);
            6'h14:   cwsDefaultStep = mkStep(8'h01, 3'h1, 4'hc, 8'h00, 4'h0, 1'b1);
            default: cwsDefaultStep = mkStep(8'hff, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1);
        endcase
    endfunction

endpackage

// File: design/cws_sequencer.sv
// Control write sequencer: step programming registers, step execution and timing.
//
// Summary of operation
// - Every step names an 8-bit target register address.
// - A 4-bit field places the data LSB anywhere from bit 0 to 15.
// - Width code n writes n+1 bits, fewer where the block would pass bit 15; wider fields need two steps.
// - Only the selected bit block changes; other target bits are preserved.
// - Data is 8 bits; bits above the selected width are ignored.
// - Step time including execution is 62.5 us times (2^D + 8).
// - A step with the end flag stops the sequencer after its delay.
// - Slot index bits 3:0 choose which RAM slot receives descriptor writes.
// - Descriptor layouts: width 14:12, lsb 11:8, address 7:0; end 14, delay 11:8, data 7:0.
// - A write to address FFh touches nothing but still takes its step time.
// - Startup and shutdown default sequences are present after power-up.
// - Programmed RAM steps survive enable changes and software reset.
// - Default startup RAM holds steps 0 to 7, ending at step 7.
// - Default shutdown ROM from step 16 powers stages down, delay code zero.
// - Go bit starts at the 6-bit first-step field; device clears it at end.
// - First-step values 0-15 are RAM, 16-58 ROM, 59-63 reserved.
// - Busy flag at 4Ah bit 0; host control writes blocked while busy.
// - Writing the cancel bit stops the sequence at once.
`timescale 1ns/1ps
module cws_sequencer #(
    parameter int unsigned TICK_CYCLES = cws_pkg::TICK_CYCLES_DEF
) (
    input  wire logic                  internal_system_clock,
    input  wire logic                  rst,
    input  wire logic                  softRst,
    input  wire logic                  sysClkOn,
    input  wire cws_pkg::cws_reg_req_t regReq,
    output logic [15:0]                regRdData,
    output logic                       ctrlWrEn,
    output cws_pkg::cws_ctrl_wr_t      ctrlWr,
    output logic                       hostWriteBlock
);
    import cws_pkg::*;

    cws_state_t   state_r;
    logic [3:0]   slotIdx_r;
    logic         enable_r;
    cws_step_t    desc_r;
    logic         goBit_r;
    logic [5:0]   firstStep_r;
    logic         doneFlag_r;
    logic [5:0]   progress_r;
    logic [5:0]   curIdx_r;
    logic [3:0]   loadIdx_r;
    logic [15:0]  divCnt_r;
    logic [16:0]  tickCnt_r;
    cws_step_t    stepHold_r;
    cws_step_t    memRdStep;
    logic [15:0]  regRdData_r;
    logic         ctrlWrEn_r;
    cws_ctrl_wr_t ctrlWr_r;
    logic         memWrEn;
    logic [3:0]   memWrIdx;
    cws_step_t    memWrStep;
    logic         busy;
    logic         hostWr;
    logic         startReq;
    logic         cancelReq;
    logic         tickPulse;
    logic         stepDone;
    logic         seqEnd;

    function automatic logic [16:0] stepTicks(input logic [3:0] d);
        stepTicks = (17'h00001 << d) + STEP_FIXED_TICKS;
    endfunction

    function automatic logic [15:0] stepMask(input cws_step_t s);
        logic [7:0] low;
        low = 8'((9'h001 << (4'(s.widthCode) + 4'h1)) - 9'h001);
        stepMask = {8'h00, low} << s.lsbPos;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign busy           = (state_r != ST_IDLE);
    assign hostWriteBlock = busy;
    assign hostWr         = regReq.wrEn && !busy;
    assign startReq  = hostWr && regReq.addr == REG_SEQ_START && regReq.wrData[GO_BIT] && enable_r && sysClkOn
                       && regReq.wrData[FIRST_MSB:0] <= ROM_LAST;
    assign cancelReq = busy && state_r != ST_LOAD && regReq.wrEn && regReq.addr == REG_SEQ_START
                       && regReq.wrData[CANCEL_BIT];
    assign tickPulse = sysClkOn && divCnt_r == 16'(TICK_CYCLES - 1);
    assign stepDone  = state_r == ST_WAIT && tickPulse && tickCnt_r == stepTicks(stepHold_r.delayCode) - 17'h00001;
    assign seqEnd    = stepDone && (stepHold_r.endFlag || curIdx_r == ROM_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor writes merge the new register into the staged descriptor before copying to RAM,
    // so either register may be written last.
    always_comb begin
        memWrStep = desc_r;
        memWrEn   = 1'b0;
        memWrIdx  = slotIdx_r;
        if (state_r == ST_LOAD) begin
            memWrEn   = 1'b1;
            memWrIdx  = loadIdx_r;
            memWrStep = cwsDefaultStep({2'b00, loadIdx_r});
        end else if (hostWr && regReq.addr == REG_TARGET_DESC) begin
            memWrEn              = 1'b1;
            memWrStep.widthCode  = regReq.wrData[WIDTH_MSB:WIDTH_LSB];
            memWrStep.lsbPos     = regReq.wrData[POS_MSB:POS_LSB];
            memWrStep.targetAddr = regReq.wrData[ADDR_MSB:0];
        end else if (hostWr && regReq.addr == REG_DATA_DESC) begin
            memWrEn              = 1'b1;
            memWrStep.endFlag    = regReq.wrData[END_BIT];
            memWrStep.delayCode  = regReq.wrData[DELAY_MSB:DELAY_LSB];
            memWrStep.writeValue = regReq.wrData[VALUE_MSB:0];
        end
    end

    cws_step_mem u_mem (
        .internal_system_clock (internal_system_clock),
        .wrEn    (memWrEn),
        .wrIdx   (memWrIdx),
        .wrStep  (memWrStep),
        .rdIdx   (curIdx_r),
        .rdStep  (memRdStep)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Programming registers; the step RAM itself is never cleared by either reset.
    always_ff @(posedge internal_system_clock) begin
        if (rst || softRst) begin
            slotIdx_r   <= '0;
            enable_r    <= 1'b0;
            desc_r      <= '0;
            firstStep_r <= '0;
        end else if (hostWr) begin
            unique case (regReq.addr)
                REG_SLOT_SELECT: begin
                    slotIdx_r <= regReq.wrData[SLOT_IDX_MSB:0];
                    enable_r  <= regReq.wrData[ENABLE_BIT];
                end
                REG_TARGET_DESC, REG_DATA_DESC: desc_r <= memWrStep;
                REG_SEQ_START:   firstStep_r <= regReq.wrData[FIRST_MSB:0];
                default: ;
            endcase
        end
    end

    // Sequencer state.
    always_ff @(posedge internal_system_clock) begin
        if (rst) begin
            state_r   <= ST_LOAD;
            loadIdx_r <= '0;
            curIdx_r  <= '0;
        end else if (softRst || cancelReq) begin
            state_r <= (state_r == ST_LOAD) ? ST_LOAD : ST_IDLE;
        end else begin
            unique case (state_r)
                ST_LOAD: begin
                    loadIdx_r <= loadIdx_r + 4'h1;
                    if (loadIdx_r == SLOT_LAST) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (startReq) begin
                        curIdx_r <= regReq.wrData[FIRST_MSB:0];
                        state_r  <= ST_FETCH;
                    end
                end
                ST_FETCH: if (sysClkOn) state_r <= ST_EXEC;
                ST_EXEC:  if (sysClkOn) state_r <= ST_WAIT;
                ST_WAIT: begin
                    if (seqEnd) begin
                        state_r <= ST_IDLE;
                    end else if (stepDone) begin
                        curIdx_r <= curIdx_r + 6'h01;
                        state_r  <= ST_FETCH;
                    end
                end
            endcase
        end
    end

    // Step timer: the divider gives one tick per delay unit, counted from the fetch cycle.
    always_ff @(posedge internal_system_clock) begin
        if (rst || softRst || !busy || state_r == ST_LOAD || stepDone) begin
            divCnt_r  <= '0;
            tickCnt_r <= '0;
        end else if (tickPulse) begin
            divCnt_r  <= '0;
            tickCnt_r <= tickCnt_r + 17'h00001;
        end else if (sysClkOn) begin
            divCnt_r <= divCnt_r + 16'h0001;
        end
    end

    // Go bit, done flag and progress index.
    always_ff @(posedge internal_system_clock) begin
        if (rst || softRst) begin
            goBit_r    <= 1'b0;
            doneFlag_r <= 1'b0;
            progress_r <= '0;
        end else begin
            if (startReq) begin
                goBit_r <= 1'b1;
            end else if (seqEnd || cancelReq) begin
                goBit_r <= 1'b0;
            end
            if (seqEnd) begin
                doneFlag_r <= 1'b1;
            end else if (hostWr && regReq.addr == REG_SEQ_STATUS && regReq.wrData[DONE_BIT]) begin
                doneFlag_r <= 1'b0;
            end
            if (state_r == ST_EXEC && sysClkOn) begin
                progress_r <= curIdx_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Masked write towards the control registers.
    always_ff @(posedge internal_system_clock) begin
        if (rst || softRst) begin
            ctrlWrEn_r <= 1'b0;
            ctrlWr_r   <= '0;
            stepHold_r <= '0;
        end else begin
            ctrlWrEn_r <= 1'b0;
            if (state_r == ST_EXEC && sysClkOn && !cancelReq) begin
                stepHold_r <= memRdStep;
                ctrlWrEn_r <= memRdStep.targetAddr != DUMMY_ADDR;
                ctrlWr_r.addr <= memRdStep.targetAddr;
                ctrlWr_r.mask <= stepMask(memRdStep);
                ctrlWr_r.data <= ({8'h00, memRdStep.writeValue} << memRdStep.lsbPos) & stepMask(memRdStep);
            end
        end
    end

    // Register readback, one cycle after the address.
    always_ff @(posedge internal_system_clock) begin
        if (rst) begin
            regRdData_r <= '0;
        end else begin
            unique case (regReq.addr)
                REG_SLOT_SELECT:  regRdData_r <= 16'({enable_r, 4'h0, slotIdx_r});
                REG_TARGET_DESC:  regRdData_r <= {1'b0, desc_r.widthCode, desc_r.lsbPos, desc_r.targetAddr};
                REG_DATA_DESC:    regRdData_r <= {1'b0, desc_r.endFlag, 2'b00, desc_r.delayCode, desc_r.writeValue};
                REG_SEQ_START:    regRdData_r <= 16'({goBit_r, 2'b00, firstStep_r});
                REG_SEQ_STATUS:   regRdData_r <= 16'({doneFlag_r, busy});
                REG_SEQ_PROGRESS: regRdData_r <= 16'(progress_r);
                default:          regRdData_r <= '0;
            endcase
        end
    end

    assign regRdData = regRdData_r;
    assign ctrlWrEn  = ctrlWrEn_r;
    assign ctrlWr    = ctrlWr_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge internal_system_clock); endclocking
    default disable iff (rst || softRst);

    logic [31:0] periodCnt_r;
    always_ff @(posedge internal_system_clock) begin
        periodCnt_r <= (state_r == ST_FETCH) ? 32'h1 : periodCnt_r + 32'h1;
    end

    sequence s_finish;
        state_r == ST_WAIT ##1 state_r == ST_IDLE;
    endsequence

    sequence s_exec_dummy;
        state_r == ST_EXEC && sysClkOn && !cancelReq && memRdStep.targetAddr == DUMMY_ADDR;
    endsequence

    property p_dummy_quiet;
        s_exec_dummy |=> !ctrlWrEn ##1 state_r == ST_WAIT || !busy;
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet) else $error("dummy step drove a write");

    property p_block_only;
        ctrlWrEn |-> (ctrlWr.data & ~ctrlWr.mask) == 16'h0000 && ctrlWr.mask != 16'h0000;
    endproperty
    a_block_only: assert property (p_block_only) else $error("write data outside mask");

    property p_width_lsb;
        ctrlWrEn |-> $countones(ctrlWr.mask) <= 32'(stepHold_r.widthCode) + 1 && ctrlWr.mask[stepHold_r.lsbPos];
    endproperty
    a_width_lsb: assert property (p_width_lsb) else $error("mask width or lsb wrong");

    property p_step_period;
        state_r == ST_FETCH && $past(state_r) == ST_WAIT && $past(sysClkOn)
            |-> periodCnt_r == 32'(stepTicks(stepHold_r.delayCode)) * TICK_CYCLES;
    endproperty
    a_step_period: assert property (p_step_period) else $error("step period mismatch");

    property p_end_stop;
        stepDone && stepHold_r.endFlag |=> state_r == ST_IDLE && doneFlag_r && progress_r == $past(curIdx_r);
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("end step did not stop");

    property p_go_cleared;
        s_finish |-> !goBit_r && !hostWriteBlock;
    endproperty
    a_go_cleared: assert property (p_go_cleared) else $error("go bit left set at end");

    property p_cancel;
        cancelReq |=> state_r == ST_IDLE && !goBit_r ##1 !ctrlWrEn;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel not honoured");

    property p_no_start;
        state_r == ST_IDLE && regReq.wrEn && regReq.addr == REG_SEQ_START && (!enable_r || !sysClkOn)
            |=> state_r == ST_IDLE [*2];
    endproperty
    a_no_start: assert property (p_no_start) else $error("start without enable or clock");

    property p_reserved;
        state_r == ST_IDLE && regReq.wrEn && regReq.addr == REG_SEQ_START && regReq.wrData[FIRST_MSB:0] > ROM_LAST
            |=> state_r == ST_IDLE && !goBit_r;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved start index ran");

    property p_busy_refuse;
        busy && regReq.wrEn && regReq.addr == REG_SLOT_SELECT |=> $stable(slotIdx_r) && $stable(enable_r);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("write accepted while busy");

endmodule

// File: design/cws_step_mem.sv
// Step descriptor store: 16 writable slots plus the fixed ROM region, registered read.
`timescale 1ns/1ps
module cws_step_mem (
    input  wire logic              internal_system_clock,
    input  wire logic              wrEn,
    input  wire logic [3:0]        wrIdx,
    input  wire cws_pkg::cws_step_t wrStep,
    input  wire logic [5:0]        rdIdx,
    output cws_pkg::cws_step_t      rdStep
);
    import cws_pkg::*;

    // No reset on the array: contents survive software reset; hard reset makes the owner reload the defaults.
    cws_step_t ram [16];

    always_ff @(posedge internal_system_clock) begin
        if (wrEn) begin
            ram[wrIdx] <= wrStep;
        end
    end

    always_ff @(posedge internal_system_clock) begin
        if (rdIdx <= RAM_LAST) begin
            rdStep <= ram[rdIdx[3:0]];
        end else begin
            rdStep <= cwsDefaultStep(rdIdx);
        end
    end

endmodule

// File: dv/control_write_sequencer_tb.sv
// Self-checking bench comparing sequencer control writes with a reference model.
`timescale 1ns/1ps
`define CHK(g, e) check(64'(g), 64'(e))
module control_write_sequencer_tb;
    import cws_pkg::*;
    localparam int TICK = 4;
    logic         internal_system_clock = 1'b0;
    logic         rst = 1'b1;
    logic         softRst = 1'b0;
    logic         sysClkOn = 1'b1;
    cws_reg_req_t regReq;
    logic [15:0]  regRdData;
    logic         ctrlWrEn;
    cws_ctrl_wr_t ctrlWr;
    logic         hostWriteBlock;
    int           fail_count = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           c0;
    logic [39:0]  gotQ[$], expQ[$], keepQ[$];
    int           gotT[$], gapQ[$], keepG[$];
    logic [31:0]  lfsr = 32'h055300fc;
    logic [15:0]  rdv;
    logic [7:0]   a, v;
    logic [3:0]   p;
    logic [2:0]   w;
    logic [1:0]   d;
    logic [7:0]   rdA [5] = '{REG_SLOT_SELECT, REG_SEQ_START, REG_SEQ_STATUS, REG_SEQ_PROGRESS, 8'h50};

    always #50 internal_system_clock = ~internal_system_clock;
    always @(posedge internal_system_clock) begin
        cyc <= cyc + 1;
        if (ctrlWrEn === 1'b1) begin
            gotQ.push_back(ctrlWr);
            gotT.push_back(cyc);
        end
    end

    cws_host_model host (.internal_system_clock(internal_system_clock), .regRdData(regRdData), .regReq(regReq));
    cws_sequencer #(.TICK_CYCLES(TICK)) dut (.internal_system_clock(internal_system_clock), .rst(rst), .softRst(softRst),
        .sysClkOn(sysClkOn), .regReq(regReq), .regRdData(regRdData), .ctrlWrEn(ctrlWrEn),
        .ctrlWr(ctrlWr), .hostWriteBlock(hostWriteBlock));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // A block of n bits at bit q carrying the low bits of x; bits past 15 fall off.
    function automatic logic [39:0] expWr(input int ad, input int n, input int q, input int x);
        int m;
        m = ((1 << n) - 1) << q;
        expWr = {ad[7:0], m[15:0], m[15:0] & 16'(x << q)};
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (hostWriteBlock !== 1'b0 && n < 5000) begin
            @(posedge internal_system_clock);
            #1;
            n++;
        end
        #1;
        `CHK(n < 5000, 1);
    endtask

    task automatic runSeq(input logic [15:0] go);
        gotQ.delete();
        gotT.delete();
        host.wr(REG_SEQ_START, go);
        waitIdle();
        `CHK(gotQ.size(), expQ.size());
        foreach (expQ[i]) begin
            if (i < gotQ.size()) begin
                `CHK(gotQ[i], expQ[i]);
                if (i > 0) `CHK(gotT[i] - gotT[i - 1], gapQ[i - 1] * TICK);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #3000000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge internal_system_clock);
        #1 rst = 1'b0;
        waitIdle();
        foreach (rdA[i]) begin
            host.rd(rdA[i], rdv);
            `CHK(rdv, 16'h0000);
        end
        $display("test reset done");
        // clock running and sequencer enabled before start-up
        // Path and gain setup lives outside this block and is taken as done.
        host.wr(REG_SLOT_SELECT, 16'h0100);
        expQ = {expWr(8'h4c, 1, 15, 1), expWr(1, 3, 7, 7), expWr(8'h60, 5, 1, 8'h11),
                expWr(8'h54, 7, 0, 8'h33), expWr(8'h60, 6, 2, 8'h3b)};
        gapQ = {72, 9, 9, 578};
        runSeq(16'h0100);
        host.rd(REG_SEQ_PROGRESS, rdv);
        `CHK(rdv, 16'h0007);
        host.rd(REG_SEQ_STATUS, rdv);
        `CHK(rdv[1:0], 2'b10);
        host.wr(REG_SEQ_STATUS, 16'h0002);
        host.rd(REG_SEQ_STATUS, rdv);
        `CHK(rdv, 16'h0000);
        host.rd(REG_SEQ_START, rdv);
        `CHK(rdv, 16'h0000);
        $display("test start-up done");
        expQ = {expWr(8'h60, 7, 1, 0), expWr(8'h54, 2, 0, 0), expWr(1, 2, 8, 0),
                expWr(8'h4c, 1, 15, 0), expWr(1, 2, 12, 0)};
        gapQ = {9, 9, 9, 9};
        runSeq(16'h0110);
        host.rd(REG_SEQ_PROGRESS, rdv);
        `CHK(rdv, 16'h0014);
        $display("test shut-down done");
        for (int k = 0; k < 4; k++) begin
            lfsr = nextRand(lfsr);
            {d, v, p, w} = lfsr[24:8];
            a = {1'b0, lfsr[6:0]};
            host.prog(4'(8 + 2 * k), {1'b0, w, p, a}, {4'h0, 2'b00, d, v});
            host.prog(4'(9 + 2 * k), {1'b0, lfsr[27:25], lfsr[31:28], 8'h33}, {8'h40, lfsr[7:0]});
            expQ = {expWr(a, int'(w) + 1, p, v), expWr(8'h33, int'(lfsr[27:25]) + 1, lfsr[31:28], lfsr[7:0])};
            gapQ = {(1 << d) + 8};
            runSeq({8'h01, 8'(8 + 2 * k)});
            if (k == 0) begin
                keepQ = expQ;
                keepG = gapQ;
            end
        end
        host.rd(REG_TARGET_DESC, rdv);
        `CHK(rdv, {1'b0, lfsr[27:25], lfsr[31:28], 8'h33});
        host.rd(REG_DATA_DESC, rdv);
        `CHK(rdv, {8'h40, lfsr[7:0]});
        $display("test programmed steps done");
        host.wr(REG_SEQ_START, 16'h0100);
        repeat (50) @(posedge internal_system_clock);
        host.wr(REG_SLOT_SELECT, 16'h0105);
        c0 = cyc;
        host.wr(REG_SEQ_START, 16'h0200);
        waitIdle();
        `CHK(cyc - c0 <= 4, 1);
        host.rd(REG_SLOT_SELECT, rdv);
        `CHK(rdv, 16'h010f);
        $display("test cancel done");
        for (int j = 0; j < 3; j++) begin
            host.wr(REG_SLOT_SELECT, j == 0 ? 16'h000f : 16'h010f);
            sysClkOn = (j != 1);
            gotQ.delete();
            host.wr(REG_SEQ_START, j == 2 ? 16'h013b : 16'h0100);
            repeat (4) @(posedge internal_system_clock);
            #1;
            `CHK({hostWriteBlock, 8'(gotQ.size())}, 0);
        end
        sysClkOn = 1'b1;
        $display("test ignored start done");
        @(posedge internal_system_clock);
        #1 softRst = 1'b1;
        @(posedge internal_system_clock);
        #1 softRst = 1'b0;
        host.wr(REG_SLOT_SELECT, 16'h0100);
        expQ = keepQ;
        gapQ = keepG;
        runSeq(16'h0108);
        $display("test retention done");
        stop_test();
    end
endmodule

// File: dv/cws_host_model.sv
// Host-side model that reaches the sequencer registers over the control interface.
`timescale 1ns/1ps
module cws_host_model (
    input  wire logic             internal_system_clock,
    input  wire logic [15:0]      regRdData,
    output cws_pkg::cws_reg_req_t regReq
);
    import cws_pkg::*;
    initial regReq = '0;

    // one write per strobe, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge internal_system_clock);
        #1 regReq = '{wrEn: 1'b1, addr: a, wrData: d};
        @(posedge internal_system_clock);
        #1 regReq = '{wrEn: 1'b0, addr: a, wrData: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge internal_system_clock);
        #1 regReq.addr = a;
        @(posedge internal_system_clock);
        #1 d = regRdData;
    endtask

    task automatic prog(input logic [3:0] s, input logic [15:0] t, input logic [15:0] v);
        wr(REG_SLOT_SELECT, {7'h00, 1'b1, 4'h0, s});
        wr(REG_TARGET_DESC, t);
        wr(REG_DATA_DESC, v);
    endtask
endmodule
